// ===== sbrc_consts.vh
`ifndef SBRC_CONSTS_VH
`define SBRC_CONSTS_VH

// Register index of the housekeeping standby configuration register.
`define SBRC_HSC_ADDR 6'h39
`define SBRC_HSC_RESET 16'h0000

// Field positions inside the register.
`define SBRC_CAL_X2_BIT 13
`define SBRC_ROUTE_BIT 8
`define SBRC_DIAG_BIT 7
`define SBRC_OUTS_BIT 6
`define SBRC_SW_BIT 5

// Bits this block stores; bits 12..9 are reserved, others belong elsewhere.
`define SBRC_OWN_MASK 16'h21E0

`endif

// ===== sbrc_standby_retention_config.v
// Function
// - Range bit doubles calibration string voltage.
// - Routing bit overrides pin four drive settings.
// - Routed pin four low in standby.
// - Routing clear gives pin four normal control; outputs keepalive gates its drive in standby.
// - Diag keepalive keeps enabled diagnostics in standby.
// - Oscillator kept: keepalive, voltage error, internal clock.
// - Outputs keepalive keeps enabled outputs in standby.
// - Switch keepalive clear opens switch in standby.
// - Switch keepalive set uses channel switch setting.
// - Fields read/write, reset to zero.
`timescale 1ns/1ps
`include "sbrc_consts.vh"

module sbrc_standby_retention_config (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Register port
  input wire reg_wr,
  input wire [5:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] housekeeping_standby_config,
  // Device state
  input wire in_standby,
  input wire diag_errors_enabled,
  input wire volt_error_enabled,
  input wire internal_clock_selected,
  input wire output_pin_four_drive_enable,
  input wire output_pin_four_value,
  input wire outputs_enabled,
  input wire channel_switch_setting,
  // Controls to the analog side and pins
  output reg calibration_range_doubler,
  output reg output_pin_four,
  output reg output_pin_four_oe,
  output reg diag_active,
  output reg oscillator_run,
  output reg general_output_active,
  output reg switch_closed
);

  // Stored fields, one flop each; the readback is rebuilt from them.
  reg cal_x2;
  reg route;
  reg diag_keep;
  reg outs_keep;
  reg sw_keep;

  // Next values of the stored fields.
  reg next_cal_x2;
  reg next_route;
  reg next_diag_keep;
  reg next_outs_keep;
  reg next_sw_keep;

  // Next values of the registered outputs.
  reg [15:0] next_readback;
  reg next_doubler;
  reg next_pin;
  reg next_pin_oe;
  reg next_diag;
  reg next_osc;
  reg next_outs;
  reg next_switch;

  // High when the host writes this register in the current cycle.
  wire hsc_write;

  // A feature may run outside standby, and in standby only when its
  // keepalive condition holds.
  function alive;
    input standby;
    input keep;
    begin
      alive = ~standby | keep;
    end
  endfunction

  // Places the stored fields in their bits; every other bit reads zero, so
  // reserved bits and bits owned by other blocks never echo host data.
  function [15:0] pack_fields;
    input f_cal;
    input f_route;
    input f_diag;
    input f_outs;
    input f_sw;
    begin
      pack_fields = 16'h0000;
      pack_fields[`SBRC_CAL_X2_BIT] = f_cal;
      pack_fields[`SBRC_ROUTE_BIT] = f_route;
      pack_fields[`SBRC_DIAG_BIT] = f_diag;
      pack_fields[`SBRC_OUTS_BIT] = f_outs;
      pack_fields[`SBRC_SW_BIT] = f_sw;
    end
  endfunction

  assign hsc_write = reg_wr && (reg_addr == `SBRC_HSC_ADDR);

  // Only the five owned bits are taken; the rest of the word is dropped.
  always @* begin
    next_cal_x2 = cal_x2;
    next_route = route;
    next_diag_keep = diag_keep;
    next_outs_keep = outs_keep;
    next_sw_keep = sw_keep;
    if (hsc_write) begin
      next_cal_x2 = reg_wdata[`SBRC_CAL_X2_BIT];
      next_route = reg_wdata[`SBRC_ROUTE_BIT];
      next_diag_keep = reg_wdata[`SBRC_DIAG_BIT];
      next_outs_keep = reg_wdata[`SBRC_OUTS_BIT];
      next_sw_keep = reg_wdata[`SBRC_SW_BIT];
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      cal_x2 <= 1'h0;
      route <= 1'h0;
      diag_keep <= 1'h0;
      outs_keep <= 1'h0;
      sw_keep <= 1'h0;
    end else begin
      cal_x2 <= next_cal_x2;
      route <= next_route;
      diag_keep <= next_diag_keep;
      outs_keep <= next_outs_keep;
      sw_keep <= next_sw_keep;
    end
  end

  // Readback and calibration control.
  always @* begin
    next_readback = pack_fields(cal_x2, route, diag_keep, outs_keep, sw_keep);
    next_doubler = cal_x2;
  end

  // Pin four: with the routing bit set, the standby indicator overrides the normal pin settings.
  always @* begin
    if (route) begin
      next_pin = ~in_standby;
      next_pin_oe = 1'h1;
    end else begin
      next_pin = output_pin_four_value;
      next_pin_oe = output_pin_four_drive_enable & alive(in_standby, outs_keep);
    end
  end

  // Standby keepalive gating. The oscillator is only released in standby,
  // so a conversion never loses its clock.
  always @* begin
    next_diag = diag_errors_enabled & alive(in_standby, diag_keep);
    next_osc = alive(in_standby,
      diag_keep & volt_error_enabled & internal_clock_selected);
    next_outs = outputs_enabled & alive(in_standby, outs_keep);
    if (in_standby && !sw_keep) begin
      next_switch = 1'h0;
    end else begin
      next_switch = channel_switch_setting;
    end
  end

  // Outputs are registered, so each follows its cause one cycle later.
  always @(posedge mclk) begin
    if (!reset_n) begin
      housekeeping_standby_config <= `SBRC_HSC_RESET;
    end else begin
      housekeeping_standby_config <= next_readback;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      calibration_range_doubler <= 1'h0;
    end else begin
      calibration_range_doubler <= next_doubler;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      output_pin_four <= 1'h0;
      output_pin_four_oe <= 1'h0;
    end else begin
      output_pin_four <= next_pin;
      output_pin_four_oe <= next_pin_oe;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      diag_active <= 1'h0;
    end else begin
      diag_active <= next_diag;
    end
  end

  // The oscillator comes out of reset running; stopping it is a standby
  // saving only, never a start-up state.
  always @(posedge mclk) begin
    if (!reset_n) begin
      oscillator_run <= 1'h1;
    end else begin
      oscillator_run <= next_osc;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      general_output_active <= 1'h0;
    end else begin
      general_output_active <= next_outs;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      switch_closed <= 1'h0;
    end else begin
      switch_closed <= next_switch;
    end
  end

endmodule // sbrc_standby_retention_config

// ===== sbrc_props.sv
`timescale 1ns/1ps
module sbrc_props (
  input wire mclk,
  input wire reset_n,
  input wire in_standby,
  input wire diag_errors_enabled,
  input wire volt_error_enabled,
  input wire internal_clock_selected,
  input wire outputs_enabled,
  input wire channel_switch_setting,
  input wire calibration_range_doubler,
  input wire output_pin_four,
  input wire output_pin_four_oe,
  input wire diag_active,
  input wire oscillator_run,
  input wire general_output_active,
  input wire switch_closed,
  input wire [15:0] housekeeping_standby_config
);
  wire [15:0] h = housekeeping_standby_config;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_cal_copy: assert property (calibration_range_doubler == h[13]) else $error("cal");
  a_pin_route:
    assert property (h[8] |-> output_pin_four_oe && output_pin_four != $past(in_standby))
    else $error("pin");
  a_sw_open:
    assert property ($past(in_standby) && !h[5] |-> !switch_closed) else $error("sw");
  a_diag_gate:
    assert property ($past(reset_n) |-> diag_active ==
      ($past(diag_errors_enabled) && (!$past(in_standby) || h[7]))) else $error("diag");
  a_osc_keep:
    assert property ($past(reset_n) |-> oscillator_run == (!$past(in_standby) ||
      (h[7] && $past(volt_error_enabled) && $past(internal_clock_selected))))
    else $error("osc");
  a_outs_gate:
    assert property ($past(reset_n) |-> general_output_active ==
      ($past(outputs_enabled) && (!$past(in_standby) || h[6]))) else $error("outs");
  a_sw_follow:
    assert property ($past(reset_n) && h[5] |-> switch_closed == $past(channel_switch_setting))
    else $error("swf");
  a_rsvd_zero:
    assert property (h[12:9] == 4'h0) else $error("rsvd");
endmodule // sbrc_props
bind sbrc_standby_retention_config sbrc_props chk (.*);

// ===== sbrc_host.sv
`timescale 1ns/1ps
module sbrc_host (input wire mclk, output reg reg_wr = 1'b0, output reg [5:0] reg_addr = 6'h00,
  output reg [15:0] reg_wdata = 16'h0000);
  // Released lines carry the inverse so stale values never look valid.
  task automatic wr(input [21:0] v); // Writes one word.
    @(posedge mclk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, v};
    @(posedge mclk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b0, ~v};
  endtask
endmodule // sbrc_host

// ===== sbrc_standby_retention_config_tb_top.sv
`timescale 1ns/1ps
module sbrc_standby_retention_config_tb_top;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic reg_wr, calibration_range_doubler, output_pin_four, output_pin_four_oe, diag_active;
  logic oscillator_run, general_output_active, switch_closed;
  logic [7:0] st = 8'h00;
  logic [5:0] reg_addr;
  logic [15:0] reg_wdata, housekeeping_standby_config, d, e;
  logic [31:0] r = 32'h00000007;
  int err_count = 0, n_compared = 0;
  always #10 mclk = ~mclk;
  sbrc_host host (.mclk(mclk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  sbrc_standby_retention_config uut (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .housekeeping_standby_config(housekeeping_standby_config),
    .in_standby(st[0]), .diag_errors_enabled(st[1]),
    .volt_error_enabled(st[2]), .internal_clock_selected(st[3]), .output_pin_four_value(st[4]),
    .output_pin_four_drive_enable(st[5]), .outputs_enabled(st[6]), .channel_switch_setting(st[7]),
    .calibration_range_doubler(calibration_range_doubler), .output_pin_four(output_pin_four),
    .output_pin_four_oe(output_pin_four_oe), .diag_active(diag_active),
    .oscillator_run(oscillator_run), .general_output_active(general_output_active),
    .switch_closed(switch_closed));
  // Expected outputs {doubler, pin, pin_oe, diag, osc, outs, switch} from fields and state.
  function automatic logic [6:0] exp_outs(input logic [15:0] f, input logic [7:0] s);
    logic sb;
    sb = s[0];
    exp_outs[6] = f[13];
    exp_outs[5] = f[8] ? !sb : s[4];
    exp_outs[4] = f[8] ? 1'h1 : (s[5] && (!sb || f[6]));
    exp_outs[3] = s[1] && (!sb || f[7]);
    exp_outs[2] = !sb || (f[7] && s[2] && s[3]);
    exp_outs[1] = s[6] && (!sb || f[6]);
    exp_outs[0] = (sb && !f[5]) ? 1'h0 : s[7];
  endfunction
  task automatic cmp_outs(input logic [6:0] x);
    logic [6:0] seen;
    seen = {calibration_range_doubler, output_pin_four, output_pin_four_oe, diag_active,
      oscillator_run, general_output_active, switch_closed};
    n_compared++;
    if (seen !== x) begin
      err_count++;
      $display("BAD outputs %h %h", x, seen);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic cmp(input logic [15:0] x);
    n_compared++;
    if (housekeeping_standby_config !== x) begin
      err_count++;
      $display("BAD readback %h %h", x, housekeeping_standby_config);
    end
  endtask
  task automatic final_report;
    $display("compared %0d bad %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    #1 reset_n = 1'h1;
    cmp(16'h0000);
    cmp_outs(7'h04);
    for (int i = 0; i < 400; i++) begin
      r = xs(r);
      st = r[31:24];
      d = i ? r[15:0] : 16'hFFFF;
      host.wr({i[0] ? r[21:16] : 6'h39, d});
      if (!i[0] || r[21:16] == 6'h39) e = {2'h0, d[13], 4'h0, d[8:5], 5'h00};
      @(posedge mclk) #1 cmp(e);
      cmp_outs(exp_outs(e, st));
    end
    $display("writes done");
    @(posedge mclk) #1 reset_n = 1'h0;
    repeat (2) @(posedge mclk);
    #1 reset_n = 1'h1;
    cmp(16'h0000);
    cmp_outs(7'h04);
    host.wr({6'h39, 16'h2100});
    e = 16'h2100;
    @(posedge mclk) #1 cmp(e);
    cmp_outs(exp_outs(e, st));
    $display("reset test done");
    final_report;
  end
endmodule // sbrc_standby_retention_config_tb_top
